// file: dv/psc_adc_model.sv
// behavioural model of the external a/d converter
`timescale 1ns/1ps
`default_nettype none
module psc_adc_model (
  input  wire logic       select_i,
  input  wire logic       sclk_i,
  input  wire logic       sout_i,
  input  wire logic [7:0] result_i,
  output logic            data_o,
  output logic            done_o,
  output logic [7:0]      config_o
);
  logic [7:0] sh_q  = '0;
  logic [7:0] cfg_q = '0;
  logic       eoc_q = 1'b0;
  logic       tog   = 1'b0;
  always #50 tog = ~tog;
  // result msb first, next bit on each falling clock
  always @(posedge select_i) sh_q = result_i;
  always @(negedge sclk_i) if (select_i) sh_q = {sh_q[6:0], ~sh_q[7]};
  assign data_o = select_i ? sh_q[7] : tog; // changing pattern when idle
  // config bits taken on the rising clock
  always @(posedge sclk_i) if (select_i) cfg_q = {cfg_q[6:0], sout_i};
  assign config_o = cfg_q;
  // done after the conversion time, edges kept off the clock edges
  always @(negedge select_i) begin
    #310 eoc_q = 1'b1;
    #230 eoc_q = 1'b0;
  end
  assign done_o = eoc_q;
endmodule
`default_nettype wire

// file: dv/psc_props.sv
// assertions on the pin state controller ports
`timescale 1ns/1ps
`default_nettype none
module psc_props (
  input wire logic              sys_clk_i,
  input wire logic              resetn_i,
  input wire logic              adc_start_i,
  input wire logic              adc_busy_o,
  input wire logic              adc_done_o,
  input wire logic [2:0]        mode_o,
  input wire psc_pkg::psc_mem_t mem_pin_o,
  input wire logic              bus_strobe_oe_o,
  input wire logic              row_col_oe_o,
  input wire psc_pkg::psc_per_t per_pin_o,
  input wire logic              card_reset_oe_o,
  input wire logic              converter_select_oe_o,
  input wire logic              key_scan_oe_o,
  input wire logic              panel_drive_oe_o,
  input wire logic              infrared_oe_o,
  input wire logic [11:0]       gpio_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // an accepted converter start
  sequence s_go;
    mode_o == 3'h0 && !adc_busy_o && adc_start_i;
  endsequence
  property p_clk;
    mode_o == 3'h1 |-> mem_pin_o.addr == '0 && mem_pin_o.row_col
      && row_col_oe_o && !bus_strobe_oe_o && !mem_pin_o.main_power_enable
      && mem_pin_o.data == '0 && !mem_pin_o.card_clock
      && !mem_pin_o.high_byte_enable && !card_reset_oe_o;
  endproperty
  a_clk: assert property (p_clk) else $error("clock reset pins");
  property p_btn;
    mode_o == 3'h2 |-> bus_strobe_oe_o && mem_pin_o.bus_strobe
      && !row_col_oe_o && mem_pin_o.main_power_enable
      && card_reset_oe_o && !per_pin_o.card_reset_out;
  endproperty
  a_btn: assert property (p_btn) else $error("button reset pins");
  property p_susp;
    mode_o == 3'h3 |-> mem_pin_o.bus_strobe && !mem_pin_o.row_col
      && row_col_oe_o && mem_pin_o.main_power_enable;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend pins");
  property p_hib;
    mode_o == 3'h4 |-> mem_pin_o.addr == '0 && !bus_strobe_oe_o
      && !mem_pin_o.row_col && !mem_pin_o.main_power_enable
      && mem_pin_o.data == '0 && !card_reset_oe_o;
  endproperty
  a_hib: assert property (p_hib) else $error("hibernate pins");
  property p_hold;
    mode_o == 3'h3 && $past(mode_o) == 3'h3 |-> $stable({per_pin_o.txd,
      per_pin_o.key_scan_out, per_pin_o.panel_drive, per_pin_o.gpio});
  endproperty
  a_hold: assert property (p_hold) else $error("suspend hold");
  property p_ser;
    mode_o inside {3'h1, 3'h2, 3'h4} |-> per_pin_o.txd && per_pin_o.rts
      && per_pin_o.dtr && per_pin_o.debug_serial_out && gpio_oe_o == '0
      && !per_pin_o.converter_clock_out && !per_pin_o.converter_config_out
      && !converter_select_oe_o && !key_scan_oe_o && !panel_drive_oe_o
      && !infrared_oe_o;
  endproperty
  a_ser: assert property (p_ser) else $error("serial pins");
  property p_sel;
    $rose(per_pin_o.converter_clock_out) |-> per_pin_o.converter_select;
  endproperty
  a_sel: assert property (p_sel) else $error("select low");
  property p_go;
    s_go |=> per_pin_o.converter_select ##[56:72] adc_done_o;
  endproperty
  a_go: assert property (p_go) else $error("transfer timing");
endmodule
`default_nettype wire

// file: dv/psc_top_tb.sv
// self-checking testbench for the pin state controller
`timescale 1ns/1ps
`default_nettype none
module psc_top_tb;
  localparam logic [17:0] MT = {3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h1};
  localparam logic [5:0]  PT = 6'h0e;
  logic              sys_clk_i = 1'b0;
  logic              resetn_i = 1'b0;
  logic [5:0]        req = '0; // clock, button, deadman, susp, hiber, timer
  psc_pkg::psc_mem_t mem_f = '0;
  psc_pkg::psc_per_t per_f = '0;
  psc_pkg::psc_mem_t mem_p;
  psc_pkg::psc_per_t per_p;
  logic [11:0]       gin = '0;
  logic [11:0]       goe = '0;
  logic [7:0]        cfg = '0;
  logic [7:0]        rv = '0;
  logic [7:0]        res, mcfg;
  logic [13:0]       save;
  logic [2:0]        mode;
  logic [31:0]       seed = 32'h158e6;
  logic              start = 1'b0;
  logic              irq = 1'b0;
  logic              din, eoc, done, busy, touch, lid, cdone;
  logic [11:0]       gsync;
  logic [15:0]       expq[$];
  int                errors = 0;
  int                n_checks = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  psc_top u_psc_top (
    .sys_clk_i, .resetn_i, .clock_unit_reset_in_i(req[0]),
    .reset_button_in_i(req[1]), .deadman_reset_i(req[2]),
    .suspend_i(req[3]), .hibernate_i(req[4]),
    .inactivity_shutdown_timer_i(req[5]), .mem_func_i(mem_f),
    .per_func_i(per_f), .gpio_oe_func_i(goe), .adc_start_i(start),
    .adc_config_i(cfg), .converter_data_in_i(din),
    .conversion_done_in_i(eoc), .panel_touch_irq_i(irq), .gpio_i(gin),
    .adc_result_o(res), .adc_done_o(done), .adc_busy_o(busy),
    .conversion_done_o(cdone), .panel_touched_o(touch),
    .battery_lid_sense_o(lid), .gpio_sync_o(gsync), .mode_o(mode),
    .mem_pin_o(mem_p), .bus_strobe_oe_o(), .row_col_oe_o(),
    .per_pin_o(per_p), .card_reset_oe_o(), .converter_select_oe_o(),
    .key_scan_oe_o(), .panel_drive_oe_o(), .infrared_oe_o(), .gpio_oe_o()
  );
  psc_adc_model u_psc_adc_model (
    .select_i(per_p.converter_select), .sclk_i(per_p.converter_clock_out),
    .sout_i(per_p.converter_config_out), .result_i(rv), .data_o(din),
    .done_o(eoc), .config_o(mcfg)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // fresh random functional values
  task automatic roll;
    seed = lfsr(lfsr(seed));
    mem_f = {seed[9:0], seed};
    per_f = {seed[1:0], ~seed};
    {goe, rv, cfg} = {seed[27:16], seed[15:0]};
  endtask
  // main sequence
  initial begin
    tick(12);
    resetn_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      req = 6'h01 << i;
      tick(3);
      chk(mode === MT[i*3 +: 3], "mode");
      chk(mem_p.main_power_enable === PT[i], "power");
    end
    req = 6'h3f;
    tick(3);
    chk(mode === 3'h1, "priority");
    req = '0;
    roll;
    tick(3);
    chk(per_p.txd === per_f.txd && mem_p.addr === mem_f.addr, "pass");
    save = {per_f.key_scan_out, per_f.panel_drive, per_f.txd};
    req = 6'h08;
    tick(1);
    roll;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(2);
    chk(busy === 1'b0, "refused");
    chk({per_p.key_scan_out, per_p.panel_drive, per_p.txd} === save, "hold");
    req = '0;
    tick(2);
    for (int t = 0; t < 4; t++) begin
      roll;
      expq.push_back({cfg, rv});
      start = 1'b1;
      tick(1);
      start = 1'b0;
      tick(1);
      for (int k = 0; k < 200 && busy !== 1'b0; k++) tick(1);
      chk(busy === 1'b0, "hang");
    end
    irq = 1'b1;
    gin = seed[11:0];
    // wait into the converter's done pulse after the last transfer
    tick(9);
    chk(touch === irq && lid === gin[9] && gsync === gin, "sync");
    chk(cdone === 1'b1, "done pin");
    chk(expq.size() == 0, "missing");
    wrap_up;
  end
  // compare each finished transfer with the oldest note
  always @(negedge sys_clk_i) begin
    if (done === 1'b1) begin
      chk(expq.size() != 0 && {mcfg, res} === expq[0], "xfer");
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end
  // cut a hang short
  initial begin
    #100000;
    errors++;
    wrap_up;
  end
endmodule
bind psc_top psc_props u_psc_props (
  .sys_clk_i, .resetn_i, .adc_start_i, .adc_busy_o, .adc_done_o, .mode_o,
  .mem_pin_o, .bus_strobe_oe_o, .row_col_oe_o, .per_pin_o,
  .card_reset_oe_o, .converter_select_oe_o, .key_scan_oe_o,
  .panel_drive_oe_o, .infrared_oe_o, .gpio_oe_o
);
`default_nettype wire

// file: logic/psc_adc_link.sv
// serial link to the external a/d converter
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_adc_link #(
  parameter int W = `PSC_ADC_W
) (
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] config_i,
  input  wire logic         data_in_i,
  output logic              busy_o,
  output logic              done_o,
  output logic [W-1:0]      result_o,
  output logic              select_o,
  output logic              sclk_o,
  output logic              sout_o
);
  logic [3:0]   div_q;
  logic [4:0]   bit_q;
  logic [W-1:0] tx_q;
  logic [W-1:0] rx_q;
  logic         run_q;

  // shift engine: select held for whole transfer
  always_ff @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    if (!resetn_i) begin
      run_q <= 1'b0; div_q <= 4'h0; bit_q <= 5'h00;
      tx_q <= '0; rx_q <= '0; sclk_o <= 1'b0; result_o <= '0;
    end else if (!run_q) begin
      if (start_i) begin
        run_q <= 1'b1; tx_q <= config_i; bit_q <= 5'h00; div_q <= 4'h0;
      end
    end else if (div_q == `PSC_ADC_DIV - 4'd1) begin
      div_q <= 4'h0;
      sclk_o <= ~sclk_o;
      if (!sclk_o) begin
        rx_q <= {rx_q[W-2:0], data_in_i};
      end else begin
        tx_q <= {tx_q[W-2:0], 1'b0};
        if (bit_q == 5'(W - 1)) begin
          run_q <= 1'b0; done_o <= 1'b1; result_o <= rx_q;
        end else begin
          bit_q <= bit_q + 5'h01;
        end
      end
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  assign busy_o   = run_q;
  assign select_o = run_q;
  assign sout_o   = run_q & tx_q[W-1];
endmodule
`default_nettype wire

// file: logic/psc_map.svh
// pin state constants for the pin state controller
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_ADDR_W      21
`define PSC_DATA_W      16
`define PSC_BOOT_MEMORY_SELECT_W     4
`define PSC_ROW_W       4
`define PSC_KEY_SCAN_OUT_W     8
`define PSC_PANEL_W     5
`define PSC_GPIO_W      12
`define PSC_LID_PIN     4'd9
`define PSC_ADC_W       8
`define PSC_ADC_DIV     4'd4
`define PSC_MODE_FULL   3'h0
`define PSC_MODE_CLKRST 3'h1
`define PSC_MODE_BTNRST 3'h2
`define PSC_MODE_SUSP   3'h3
`define PSC_MODE_HIBER  3'h4
`endif

// file: logic/psc_pkg.sv
// types for the pin state controller
`default_nettype none
`include "psc_map.svh"
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_FULL   = 3'h0,
    PSC_CLKRST = 3'h1,
    PSC_BTNRST = 3'h2,
    PSC_SUSP   = 3'h3,
    PSC_HIBER  = 3'h4
  } psc_mode_t;

  // memory side drive group: pin values only, the output enables are separate ports
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] data;
    logic        card_clock;
    logic        high_byte_enable;
    logic        bus_strobe;   // rom, display and isa strobes, common level
    logic        row_col;      // dram row and column strobes
    logic        main_power_enable;
  } psc_mem_t;

  typedef struct packed {
    logic        txd;
    logic        rts;
    logic        dtr;
    logic        infrared_data_out;
    logic        debug_serial_out;
    logic [7:0]  key_scan_out;
    logic        converter_select;
    logic        converter_clock_out;
    logic        converter_config_out;
    logic [4:0]  panel_drive;
    logic [11:0] gpio;
    logic        card_reset_out;
  } psc_per_t;
endpackage
`default_nettype wire

// file: logic/psc_top.sv
// pin state controller: forces pin states by reset source and power mode
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_top (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // reset source and power mode from power management
  input  wire logic        clock_unit_reset_in_i,
  input  wire logic        reset_button_in_i,
  input  wire logic        deadman_reset_i,
  input  wire logic        suspend_i,
  input  wire logic        hibernate_i,
  input  wire logic        inactivity_shutdown_timer_i,
  // functional values from peripheral logic
  input  wire psc_pkg::psc_mem_t mem_func_i,
  input  wire psc_pkg::psc_per_t per_func_i,
  input  wire logic [11:0] gpio_oe_func_i,
  input  wire logic        adc_start_i,
  input  wire logic [7:0]  adc_config_i,
  // converter and panel pins
  input  wire logic        converter_data_in_i,
  input  wire logic        conversion_done_in_i,
  input  wire logic        panel_touch_irq_i,
  input  wire logic [11:0] gpio_i,
  // results to peripheral logic
  output logic [7:0]       adc_result_o,
  output logic             adc_done_o,
  output logic             adc_busy_o,
  output logic             conversion_done_o,
  output logic             panel_touched_o,
  output logic             battery_lid_sense_o,
  output logic [11:0]      gpio_sync_o,
  output logic [2:0]       mode_o,
  // pin drive, value and enable (enable high = driving)
  output psc_pkg::psc_mem_t mem_pin_o,
  output logic             bus_strobe_oe_o,
  output logic             row_col_oe_o,
  output psc_pkg::psc_per_t per_pin_o,
  output logic             card_reset_oe_o,
  output logic             converter_select_oe_o,
  output logic             key_scan_oe_o,
  output logic             panel_drive_oe_o,
  output logic             infrared_oe_o,
  output logic [11:0]      gpio_oe_o
);
  psc_pkg::psc_mode_t mode_d, mode_q;
  psc_pkg::psc_per_t  per_live, per_hold_q;
  logic [11:0]        gpio_oe_hold_q;
  logic [14:0]        sync1_q, sync2_q;
  logic               adc_sel, adc_clk, adc_out;
  logic               adc_go;

  // one place decides fullspeed for the converter start and the suspend capture
  function automatic logic is_fullspeed(input psc_pkg::psc_mode_t m);
    return (m == psc_pkg::PSC_FULL);
  endfunction

  // pick exactly one forced set, resets take priority
  // several requests may be high together; resets outrank power modes
  always_comb begin
    if (clock_unit_reset_in_i)                   mode_d = psc_pkg::PSC_CLKRST;
    else if (reset_button_in_i | deadman_reset_i) mode_d = psc_pkg::PSC_BTNRST;
    else if (hibernate_i | inactivity_shutdown_timer_i)
      mode_d = psc_pkg::PSC_HIBER;
    else if (suspend_i)                          mode_d = psc_pkg::PSC_SUSP;
    else                                         mode_d = psc_pkg::PSC_FULL;
  end

  // mode register
  // reset lands in the clock unit reset set so the pins start safe
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) mode_q <= psc_pkg::PSC_CLKRST;
    else           mode_q <= mode_d;
  end
  // power management sees the mode that is applied to the pins
  assign mode_o = mode_q;

  // two-stage synchronisers for pin inputs
  // the converter data bit rides in here too, so the link sees it late
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sync1_q <= 15'h0000;
      sync2_q <= 15'h0000;
    end else begin
      sync1_q <= {converter_data_in_i, conversion_done_in_i,
                  panel_touch_irq_i, gpio_i};
      sync2_q <= sync1_q;
    end
  end
  assign conversion_done_o   = sync2_q[13];
  assign panel_touched_o     = sync2_q[12];
  assign gpio_sync_o         = sync2_q[11:0];
  // pin nine is only ever an input: it senses the battery lid
  assign battery_lid_sense_o = sync2_q[`PSC_LID_PIN];

  // the link only starts in fullspeed; a refused start leaves no trace
  assign adc_go = adc_start_i & is_fullspeed(mode_q);

  psc_adc_link #(.W(`PSC_ADC_W)) u_adc (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .start_i   (adc_go),
    .config_i  (adc_config_i),
    .data_in_i (sync2_q[14]),
    .busy_o    (adc_busy_o),
    .done_o    (adc_done_o),
    .result_o  (adc_result_o),
    .select_o  (adc_sel),
    .sclk_o    (adc_clk),
    .sout_o    (adc_out)
  );

  // live peripheral values with converter pins from the link
  always_comb begin
    per_live = per_func_i;
    per_live.converter_select     = adc_sel;
    per_live.converter_clock_out  = adc_clk;
    per_live.converter_config_out = adc_out;
  end

  // capture fullspeed levels for suspend hold
  // capture on every fullspeed cycle; the last one before entry wins
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      per_hold_q     <= '0;
      gpio_oe_hold_q <= 12'h000;
    end else if (is_fullspeed(mode_q)) begin
      per_hold_q     <= per_live;
      gpio_oe_hold_q <= gpio_oe_func_i; // pin nine stays input
      gpio_oe_hold_q[`PSC_LID_PIN] <= 1'b0;
    end
  end

  // memory side pins
  // address and data are don't-care in button reset and suspend, so the
  // functional values keep flowing there rather than a made-up level
  always_comb begin
    mem_pin_o       = mem_func_i;
    bus_strobe_oe_o = 1'b1;
    row_col_oe_o    = 1'b1;
    case (mode_q)
      psc_pkg::PSC_CLKRST: begin
        mem_pin_o = '0;
        mem_pin_o.row_col = 1'b1;
        bus_strobe_oe_o   = 1'b0;
      end
      psc_pkg::PSC_BTNRST: begin
        mem_pin_o.bus_strobe        = 1'b1;
        mem_pin_o.main_power_enable = 1'b1;
        row_col_oe_o                = 1'b0;
      end
      psc_pkg::PSC_SUSP: begin
        mem_pin_o.bus_strobe        = 1'b1;
        mem_pin_o.row_col           = 1'b0;
        mem_pin_o.main_power_enable = 1'b1;
      end
      psc_pkg::PSC_HIBER: begin
        mem_pin_o = '0;
        bus_strobe_oe_o = 1'b0;
      end
      psc_pkg::PSC_FULL: begin
        mem_pin_o = mem_func_i;
      end
      default: begin
        mem_pin_o = '0;
        bus_strobe_oe_o = 1'b0;
      end
    endcase
  end

  // peripheral side pins
  // a transfer already running when suspend comes is left to finish, while
  // the pins keep showing the levels captured at entry
  always_comb begin
    per_pin_o             = per_live;
    card_reset_oe_o       = 1'b1;
    converter_select_oe_o = 1'b1;
    key_scan_oe_o         = 1'b1;
    panel_drive_oe_o      = 1'b1;
    infrared_oe_o         = 1'b1;
    gpio_oe_o             = gpio_oe_func_i;
    // pin nine never drives, whatever the functional enable says
    gpio_oe_o[`PSC_LID_PIN] = 1'b0;
    case (mode_q)
      psc_pkg::PSC_SUSP: begin
        per_pin_o = per_hold_q;
        gpio_oe_o = gpio_oe_hold_q;
      end
      psc_pkg::PSC_CLKRST, psc_pkg::PSC_BTNRST, psc_pkg::PSC_HIBER: begin
        per_pin_o = '0;
        per_pin_o.txd = 1'b1;
        per_pin_o.rts = 1'b1;
        per_pin_o.dtr = 1'b1;
        per_pin_o.debug_serial_out = 1'b1;
        converter_select_oe_o = 1'b0;
        key_scan_oe_o    = 1'b0;
        panel_drive_oe_o = 1'b0;
        infrared_oe_o    = 1'b0;
        gpio_oe_o        = 12'h000;
        card_reset_oe_o  = (mode_q == psc_pkg::PSC_BTNRST);
      end
      default: begin
        per_pin_o = per_live;
      end
    endcase
  end
endmodule
`default_nettype wire
